/* logic/interrupt_sfr_unit.sv */
// interrupt enable, level and flag registers with request selection
// assumes all inputs synchronous to clk_in; the cpu takes the
// presented request with irq_ack_in and ends a routine with reti_in
`timescale 1ns/1ns
`default_nettype none
module interrupt_sfr_unit (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // register port
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  output logic      [7:0] sfr_rdata_out,
  // standard sources, already flagged by their own units
  input  wire logic       ext_irq0_req_in,
  input  wire logic       ext_irq1_req_in,
  input  wire logic       t0_overflow_in,
  input  wire logic       t1_overflow_in,
  input  wire logic       t2_overflow_in,
  input  wire logic       t2_external_flag_in,
  input  wire logic       uart_tx_done_in,
  input  wire logic       uart_rx_done_in,
  // extended sources
  input  wire logic       radio_match_in,
  input  wire logic       radio_rx_ready_in,
  input  wire logic       spi_byte_done_in,
  input  wire logic       adc_conv_done_in,
  input  wire logic       wakeup_event_in,
  // cpu side
  input  wire logic       irq_ack_in,
  input  wire logic       reti_in,
  output logic            irq_req_out,
  output logic            irq_high_out,
  output logic      [3:0] irq_index_out,
  output logic      [7:0] irq_vector_out,
  output logic            in_service_high_out,
  output logic            in_service_low_out
);

  irq_sfr_pkg::unit_state_t state_reg;
  irq_sfr_pkg::unit_state_t state_next;
  irq_sfr_pkg::sfr_req_t    bus;
  irq_sfr_pkg::irq_sel_t    sel;

  logic [10:0] raw_req;
  logic [10:0] enable_vec;
  logic [10:0] level_vec;
  logic [10:0] pending;
  logic        hi_busy_next;
  logic        lo_busy_next;
  logic        ack_taken;
  logic [7:0]  read_value;
  logic        wr_ext_flags;
  logic        wr_wakeup;
  logic        match_rise;
  logic        rx_ready_rise;
  logic        adc_rise;

  assign bus.addr  = sfr_addr_in;
  assign bus.wdata = sfr_wdata_in;
  assign bus.wr    = sfr_wr_in;
  assign bus.rd    = sfr_rd_in;

  assign wr_ext_flags = bus.wr && bus.addr == irq_sfr_pkg::EXT_FLAGS_ADDR;
  assign wr_wakeup    = bus.wr && bus.addr == irq_sfr_pkg::WAKEUP_ADDR;

  assign match_rise    = radio_match_in & ~state_reg.match_prev;
  assign rx_ready_rise = radio_rx_ready_in & ~state_reg.rx_ready_prev;
  assign adc_rise      = adc_conv_done_in & ~state_reg.adc_prev;

  // request lines in natural priority order
  always_comb begin
    raw_req = '0;
    raw_req[irq_sfr_pkg::SRC_X0] = ext_irq0_req_in;
    raw_req[irq_sfr_pkg::SRC_T0] = t0_overflow_in;
    raw_req[irq_sfr_pkg::SRC_X1] = ext_irq1_req_in;
    raw_req[irq_sfr_pkg::SRC_T1] = t1_overflow_in;
    // one serial request from either done flag
    raw_req[irq_sfr_pkg::SRC_UART] = uart_tx_done_in | uart_rx_done_in;
    // one timer 2 request from either flag
    raw_req[irq_sfr_pkg::SRC_T2] = t2_overflow_in | t2_external_flag_in;
    // flags set by software request like hardware ones
    raw_req[irq_sfr_pkg::SRC_ADC]   = state_reg.ext_flags[0];
    raw_req[irq_sfr_pkg::SRC_SPI]   = state_reg.ext_flags[1];
    raw_req[irq_sfr_pkg::SRC_RX]    = state_reg.ext_flags[2];
    raw_req[irq_sfr_pkg::SRC_MATCH] = state_reg.ext_flags[3];
    // level request, recurs until the flag is cleared
    // software set wakeup flag requests too
    raw_req[irq_sfr_pkg::SRC_WAKEUP] = state_reg.wakeup_flag;
  end

  // standard register bit 5..0 order is t2, uart, t1, x1, t0, x0
  always_comb begin
    enable_vec = '0;
    enable_vec[irq_sfr_pkg::SRC_X0]   = state_reg.std_en[0];
    enable_vec[irq_sfr_pkg::SRC_T0]   = state_reg.std_en[1];
    enable_vec[irq_sfr_pkg::SRC_X1]   = state_reg.std_en[2];
    enable_vec[irq_sfr_pkg::SRC_T1]   = state_reg.std_en[3];
    enable_vec[irq_sfr_pkg::SRC_UART] = state_reg.std_en[4];
    enable_vec[irq_sfr_pkg::SRC_T2]   = state_reg.std_en[5];
    enable_vec[irq_sfr_pkg::SRC_ADC]    = state_reg.ext_en[0];
    enable_vec[irq_sfr_pkg::SRC_SPI]    = state_reg.ext_en[1];
    enable_vec[irq_sfr_pkg::SRC_RX]     = state_reg.ext_en[2];
    enable_vec[irq_sfr_pkg::SRC_MATCH]  = state_reg.ext_en[3];
    enable_vec[irq_sfr_pkg::SRC_WAKEUP] = state_reg.ext_en[4];
  end

  always_comb begin
    level_vec = '0;
    level_vec[irq_sfr_pkg::SRC_X0]   = state_reg.std_level[0];
    level_vec[irq_sfr_pkg::SRC_T0]   = state_reg.std_level[1];
    level_vec[irq_sfr_pkg::SRC_X1]   = state_reg.std_level[2];
    level_vec[irq_sfr_pkg::SRC_T1]   = state_reg.std_level[3];
    level_vec[irq_sfr_pkg::SRC_UART] = state_reg.std_level[4];
    level_vec[irq_sfr_pkg::SRC_T2]   = state_reg.std_level[5];
    level_vec[irq_sfr_pkg::SRC_ADC]    = state_reg.ext_level[0];
    level_vec[irq_sfr_pkg::SRC_SPI]    = state_reg.ext_level[1];
    level_vec[irq_sfr_pkg::SRC_RX]     = state_reg.ext_level[2];
    level_vec[irq_sfr_pkg::SRC_MATCH]  = state_reg.ext_level[3];
    level_vec[irq_sfr_pkg::SRC_WAKEUP] = state_reg.ext_level[4];
  end

  // gate high leaves only the own enable
  assign pending = state_reg.global_irq_gate ?
                   (raw_req & enable_vec) : 11'h000;

  // in-service levels as they will stand after this edge; feeding the
  // selector with these keeps a just-taken request from showing twice
  assign ack_taken = irq_ack_in && state_reg.req.valid;

  always_comb begin
    hi_busy_next = state_reg.hi_busy;
    lo_busy_next = state_reg.lo_busy;
    if (reti_in) begin
      // the innermost routine returns first
      if (state_reg.hi_busy) begin
        hi_busy_next = 1'b0;
      end else begin
        lo_busy_next = 1'b0;
      end
    end
    // record the level now in service
    if (ack_taken) begin
      if (state_reg.req.high) begin
        hi_busy_next = 1'b1;
      end else begin
        lo_busy_next = 1'b1;
      end
    end
  end

  irq_select u_select (
    .pending_in (pending),
    .level_in   (level_vec),
    .hi_busy_in (hi_busy_next),
    .lo_busy_in (lo_busy_next),
    .sel_out    (sel)
  );

  // read mux; reserved bits are forced here
  always_comb begin
    case (bus.addr)
      irq_sfr_pkg::STD_EN_ADDR: begin
        read_value = {state_reg.global_irq_gate, 1'b0, state_reg.std_en};
      end
      irq_sfr_pkg::STD_LEVEL_ADDR: begin
        read_value = irq_sfr_pkg::STD_LEVEL_ONES |
                     {2'b00, state_reg.std_level};
      end
      irq_sfr_pkg::EXT_FLAGS_ADDR: begin
        read_value = irq_sfr_pkg::EXT_FLAGS_ONES |
                     {state_reg.ext_flags, 4'h0};
      end
      irq_sfr_pkg::WAKEUP_ADDR: begin
        // bit 6 reads one, the unused top bit reads zero
        read_value = irq_sfr_pkg::WAKEUP_ONES |
                     {4'h0, state_reg.wakeup_flag, 3'h0};
      end
      irq_sfr_pkg::EXT_EN_ADDR: begin
        read_value = irq_sfr_pkg::EXT_EN_ONES | {3'h0, state_reg.ext_en};
      end
      irq_sfr_pkg::EXT_LEVEL_ADDR: begin
        read_value = irq_sfr_pkg::EXT_LEVEL_ONES |
                     {3'h0, state_reg.ext_level};
      end
      default: begin
        read_value = irq_sfr_pkg::UNMAPPED_DATA;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;

    state_next.match_prev    = radio_match_in;
    state_next.rx_ready_prev = radio_rx_ready_in;
    state_next.adc_prev      = adc_conv_done_in;

    // only a software write clears a flag
    if (wr_ext_flags) begin
      state_next.ext_flags = bus.wdata[7:irq_sfr_pkg::EXT_FLAGS_LSB];
    end
    // hardware set wins over a clearing write in the same cycle
    // match flag set
    if (match_rise) begin
      state_next.ext_flags[3] = 1'b1;
    end
    if (rx_ready_rise) begin
      state_next.ext_flags[2] = 1'b1;
    end
    if (spi_byte_done_in) begin
      state_next.ext_flags[1] = 1'b1;
    end
    if (adc_rise) begin
      state_next.ext_flags[0] = 1'b1;
    end

    // software may set or clear the wakeup flag
    if (wr_wakeup) begin
      state_next.wakeup_flag = bus.wdata[irq_sfr_pkg::WAKEUP_FLAG_BIT];
    end
    // any wakeup source sets the flag
    if (wakeup_event_in) begin
      state_next.wakeup_flag = 1'b1;
    end

    if (bus.wr) begin
      case (bus.addr)
        irq_sfr_pkg::STD_EN_ADDR: begin
          state_next.global_irq_gate = bus.wdata[irq_sfr_pkg::GATE_BIT];
          state_next.std_en          = bus.wdata[5:0];
        end
        irq_sfr_pkg::STD_LEVEL_ADDR: begin
          state_next.std_level = bus.wdata[5:0];
        end
        irq_sfr_pkg::EXT_EN_ADDR: begin
          state_next.ext_en = bus.wdata[4:0];
        end
        irq_sfr_pkg::EXT_LEVEL_ADDR: begin
          state_next.ext_level = bus.wdata[4:0];
        end
        default: begin
          state_next.ext_en = state_reg.ext_en;
        end
      endcase
    end

    state_next.hi_busy    = hi_busy_next;
    state_next.lo_busy    = lo_busy_next;
    state_next.req        = sel;
    state_next.req_vector = sel.valid ?
                            irq_sfr_pkg::VECTOR_TABLE[sel.index] : 8'h00;

    state_next.rd_data = bus.rd ? read_value : 8'h00;

    if (reset_in) begin
      state_next                 = '0;
      state_next.std_en          = irq_sfr_pkg::STD_RESET;
      state_next.std_level       = irq_sfr_pkg::STD_RESET;
      state_next.ext_en          = irq_sfr_pkg::EXT_RESET;
      state_next.ext_level       = irq_sfr_pkg::EXT_RESET;
    end
  end

  always_ff @(posedge clk_in) begin
    state_reg <= state_next;
  end

  assign sfr_rdata_out       = state_reg.rd_data;
  assign irq_req_out         = state_reg.req.valid;
  assign irq_high_out        = state_reg.req.high;
  assign irq_index_out       = state_reg.req.index;
  assign irq_vector_out      = state_reg.req_vector;
  assign in_service_high_out = state_reg.hi_busy;
  assign in_service_low_out  = state_reg.lo_busy;

endmodule
`default_nettype wire

/* logic/irq_sfr_pkg.sv */
// Functional notes
// - global gate at zero masks every interrupt request
// - global gate at one: each source follows its own enable bit
// - t2_irq_en gates one timer 2 request from overflow or external flag
// - uart_irq_en gates one serial request from tx or rx done
// - standard enables gate timer 1, external 1, timer 0, external 0
// - standard level bits 5..0: one is high level, zero low
// - rising edge on radio_match sets match_flag
// - rising edge on radio_rx_ready sets rx_ready_flag
// - spi byte done sets spi_done_flag
// - rising edge on adc_conv_done sets adc_done_flag
// - extended flags never self clear; software writes zero to clear
// - software write of one sets a flag and requests if enabled
// - any wakeup event, gpio or rtc, sets wakeup_flag
// - wakeup request stays while wakeup_flag set; software must clear it
// - software set of wakeup_flag requests when wakeup_irq_en set
// - extended enables: bit 4 wakeup, bits 3..0 match, rx, spi, adc
// - extended level bits: bit 4 wakeup, bits 3..0 match, rx, spi, adc
// - reserved bits reading one: level 7, flags 3, wakeup 6, ext 7..5
// - reserved bits reading zero in enable, level, flag, wakeup registers
// - assigned level beats natural order when selecting
// - same level requests resolve by natural priority
// - a routine is preempted only by a higher level request
//
// constants and carrier types for the interrupt register unit
// assumes an 8-bit special register space driven by the cpu core
`default_nettype none
package irq_sfr_pkg;

  localparam logic [7:0] EXT_FLAGS_ADDR  = 8'h91;
  localparam logic [7:0] STD_EN_ADDR     = 8'ha8;
  localparam logic [7:0] STD_LEVEL_ADDR  = 8'hb8;
  localparam logic [7:0] WAKEUP_ADDR     = 8'hd8;
  localparam logic [7:0] EXT_EN_ADDR     = 8'he8;
  localparam logic [7:0] EXT_LEVEL_ADDR  = 8'hf8;

  localparam int GATE_BIT        = 7;
  localparam int WAKEUP_FLAG_BIT = 3;
  localparam int EXT_FLAGS_LSB   = 4;

  localparam logic [7:0] STD_LEVEL_ONES = 8'h80;
  localparam logic [7:0] EXT_FLAGS_ONES = 8'h08;
  localparam logic [7:0] WAKEUP_ONES    = 8'h40;
  localparam logic [7:0] EXT_EN_ONES    = 8'he0;
  localparam logic [7:0] EXT_LEVEL_ONES = 8'he0;
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00;

  // all writable bits reset to zero
  localparam logic [5:0] STD_RESET = 6'h00;
  localparam logic [4:0] EXT_RESET = 5'h00;

  // sources in natural priority order, index 0 is best
  localparam int NUM_SRC    = 11;
  localparam int SRC_X0     = 0;
  localparam int SRC_T0     = 1;
  localparam int SRC_X1     = 2;
  localparam int SRC_T1     = 3;
  localparam int SRC_UART   = 4;
  localparam int SRC_T2     = 5;
  localparam int SRC_ADC    = 6;
  localparam int SRC_SPI    = 7;
  localparam int SRC_RX     = 8;
  localparam int SRC_MATCH  = 9;
  localparam int SRC_WAKEUP = 10;

  localparam logic [7:0] VECTOR_TABLE [NUM_SRC] = '{
    8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
    8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63
  };

  typedef struct packed {
    logic       valid;
    logic       high;
    logic [3:0] index;
  } irq_sel_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  typedef struct packed {
    logic       match_prev;
    logic       rx_ready_prev;
    logic       adc_prev;
    logic [3:0] ext_flags;
    logic       wakeup_flag;
    logic       global_irq_gate;
    logic [5:0] std_en;
    logic [5:0] std_level;
    logic [4:0] ext_en;
    logic [4:0] ext_level;
    logic       hi_busy;
    logic       lo_busy;
    irq_sel_t   req;
    logic [7:0] req_vector;
    logic [7:0] rd_data;
  } unit_state_t;

endpackage
`default_nettype wire

/* logic/irq_select.sv */
// picks the request to present to the cpu among pending sources
// assumes pending already gated by enables and the global gate
`timescale 1ns/1ns
`default_nettype none
module irq_select (
  input  wire logic [10:0]          pending_in,
  input  wire logic [10:0]          level_in,
  input  wire logic                 hi_busy_in,
  input  wire logic                 lo_busy_in,
  output irq_sfr_pkg::irq_sel_t     sel_out
);

  logic [10:0] hi_cand;
  logic [10:0] lo_cand;
  logic        hi_found;
  logic        lo_found;
  logic [3:0]  hi_idx;
  logic [3:0]  lo_idx;

  genvar g;
  generate
    for (g = 0; g < irq_sfr_pkg::NUM_SRC; g++) begin : g_cand
      assign hi_cand[g] = pending_in[g] & level_in[g];
      assign lo_cand[g] = pending_in[g] & ~level_in[g];
    end
  endgenerate

  always_comb begin
    hi_found = 1'b0;
    lo_found = 1'b0;
    hi_idx   = 4'h0;
    lo_idx   = 4'h0;
    for (int i = irq_sfr_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (hi_cand[i]) begin
        hi_found = 1'b1;
        hi_idx   = 4'(i);
      end
      if (lo_cand[i]) begin
        lo_found = 1'b1;
        lo_idx   = 4'(i);
      end
    end
    sel_out = '0;
    if (hi_found && !hi_busy_in) begin
      sel_out.valid = 1'b1;
      sel_out.high  = 1'b1;
      sel_out.index = hi_idx;
    end else if (lo_found && !hi_busy_in && !lo_busy_in) begin
      sel_out.valid = 1'b1;
      sel_out.high  = 1'b0;
      sel_out.index = lo_idx;
    end
  end

endmodule
`default_nettype wire

/* verif/interrupt_sfr_unit_assertions.sv */
// port-level checker for the interrupt register unit
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module irq_unit_checker (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       irq_ack_in,
  input wire logic       irq_req_out,
  input wire logic       irq_high_out,
  input wire logic [3:0] irq_index_out,
  input wire logic       in_service_high_out,
  input wire logic       in_service_low_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // shadow of the global gate, seen only through bus writes
  logic gate_reg;
  always_ff @(posedge clk_in) begin
    if (reset_in)
      gate_reg <= 1'b0;
    else if (sfr_wr_in && sfr_addr_in == 8'ha8)
      gate_reg <= sfr_wdata_in[7];
  end
  property p_gate_masks;
    !gate_reg && !$past(gate_reg) |-> !irq_req_out;
  endproperty
  a_gate_masks: assert property (p_gate_masks)
    else $error("request while gate off");
  property p_std_rsv;
    sfr_rd_in && sfr_addr_in inside {8'ha8, 8'hb8} |=> !sfr_rdata_out[6];
  endproperty
  a_std_rsv: assert property (p_std_rsv)
    else $error("standard reserved bit not zero");
  property p_lvl_rsv;
    sfr_rd_in && sfr_addr_in == 8'hb8 |=> sfr_rdata_out[7];
  endproperty
  a_lvl_rsv: assert property (p_lvl_rsv)
    else $error("level reserved bit not one");
  property p_ext_rsv;
    sfr_rd_in && sfr_addr_in inside {8'he8, 8'hf8}
      |=> sfr_rdata_out[7:5] == 3'b111;
  endproperty
  a_ext_rsv: assert property (p_ext_rsv)
    else $error("extended reserved bits wrong");
  property p_flag_rsv;
    sfr_rd_in && sfr_addr_in == 8'h91 |=> sfr_rdata_out[3:0] == 4'h8;
  endproperty
  a_flag_rsv: assert property (p_flag_rsv)
    else $error("flag reserved bits wrong");
  property p_wake_rsv;
    sfr_rd_in && sfr_addr_in == 8'hd8
      |=> sfr_rdata_out[6:4] == 3'b100 && sfr_rdata_out[2:0] == 3'b000;
  endproperty
  a_wake_rsv: assert property (p_wake_rsv)
    else $error("wakeup reserved bits wrong");
  property p_high_blocks;
    in_service_high_out && $past(in_service_high_out) |-> !irq_req_out;
  endproperty
  a_high_blocks: assert property (p_high_blocks)
    else $error("request during high service");
  property p_low_preempt;
    in_service_low_out && $past(in_service_low_out) && irq_req_out
      |-> irq_high_out;
  endproperty
  a_low_preempt: assert property (p_low_preempt)
    else $error("low request during low service");
  property p_ack_level;
    irq_ack_in && irq_req_out
      |=> ($past(irq_high_out) ? in_service_high_out : in_service_low_out);
  endproperty
  a_ack_level: assert property (p_ack_level)
    else $error("taken request not in service");
  property p_wake_recur;
    irq_req_out && irq_index_out == 4'd10 && !irq_ack_in && !sfr_wr_in
      && !$past(sfr_wr_in) |=> irq_req_out;
  endproperty
  a_wake_recur: assert property (p_wake_recur)
    else $error("wakeup request dropped");
  c_high_ack: cover property (irq_ack_in && irq_req_out && irq_high_out);
  c_nested: cover property (in_service_low_out && in_service_high_out);
  c_wake_ack: cover property (irq_ack_in && irq_index_out == 4'd10);
endmodule
bind interrupt_sfr_unit irq_unit_checker i_irq_unit_checker (
  .clk_in(clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr_in),
  .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
  .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out),
  .irq_ack_in(irq_ack_in), .irq_req_out(irq_req_out),
  .irq_high_out(irq_high_out), .irq_index_out(irq_index_out),
  .in_service_high_out(in_service_high_out),
  .in_service_low_out(in_service_low_out));
`default_nettype wire

/* verif/cpu_model.sv */
// cpu core model: takes presented requests and returns after hold cycles
// assumes the bench raises auto_in only when it expects a request
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       irq_req_in,
  input  wire logic       auto_in,
  input  wire logic [7:0] hold_in,
  output var  logic       ack_out,
  output var  logic       reti_out
);
  logic [3:0] depth_reg;
  logic [7:0] timer_reg;
  always_ff @(posedge clk_in) begin
    ack_out <= 1'b0;
    reti_out <= 1'b0;
    if (reset_in) begin
      depth_reg <= 4'h0;
      timer_reg <= 8'h00;
    end else if (auto_in && irq_req_in && !ack_out) begin
      ack_out <= 1'b1;
      depth_reg <= depth_reg + 4'h1;
      timer_reg <= hold_in;
    end else if (timer_reg != 8'h00) begin
      timer_reg <= timer_reg - 8'h01;
    end else if (depth_reg != 4'h0) begin
      reti_out <= 1'b1;
      depth_reg <= depth_reg - 4'h1;
      timer_reg <= hold_in;
    end
  end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the interrupt register unit
// assumes the cpu model answers requests while auto is high
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        auto = 1'b0;
  logic        rd_d = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  hold = 8'h02;
  logic [12:0] src = 13'h0000;
  logic [7:0]  rdata, vec, v, fa, fb, fo;
  logic        ack, reti, req, high, srv_h, srv_l;
  logic [3:0]  index;
  int          err_total = 0;
  int          checked = 0;
  int          k;
  logic [8:0]  exp_irq[$];
  logic [8:0]  e_irq;
  logic [7:0]  exp_rd[$];
  logic [7:0]  ad [7] = '{8'h91, 8'ha8, 8'hb8, 8'hd8, 8'he8, 8'hf8, 8'h90};
  logic [7:0]  on [7] = '{8'h08, 8'h00, 8'h80, 8'h40, 8'he0, 8'he0, 8'h00};
  logic [7:0]  wm [7] = '{8'hf0, 8'hbf, 8'h3f, 8'h08, 8'h1f, 8'h1f, 8'h00};
  interrupt_sfr_unit i_interrupt_sfr_unit (
    .clk_in(clk_in), .reset_in(reset_in), .sfr_addr_in(addr),
    .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_rdata_out(rdata), .ext_irq0_req_in(src[0]),
    .t0_overflow_in(src[1]), .ext_irq1_req_in(src[2]),
    .t1_overflow_in(src[3]), .uart_tx_done_in(src[4]),
    .uart_rx_done_in(src[5]), .t2_overflow_in(src[6]),
    .t2_external_flag_in(src[7]), .adc_conv_done_in(src[8]),
    .spi_byte_done_in(src[9]), .radio_rx_ready_in(src[10]),
    .radio_match_in(src[11]), .wakeup_event_in(src[12]),
    .irq_ack_in(ack), .reti_in(reti), .irq_req_out(req),
    .irq_high_out(high), .irq_index_out(index), .irq_vector_out(vec),
    .in_service_high_out(srv_h), .in_service_low_out(srv_l));
  cpu_model i_cpu_model (
    .clk_in(clk_in), .reset_in(reset_in), .irq_req_in(req),
    .auto_in(auto), .hold_in(hold), .ack_out(ack), .reti_out(reti));
  initial forever #25 clk_in = ~clk_in;
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results;
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
  endtask
  // want 1: a taken request; want 0: no routine in service
  task automatic wait_on(input bit want);
    int n;
    n = 0;
    @(posedge clk_in);
    while ((want ? ack : !(srv_h | srv_l)) !== 1'b1) begin
      n++;
      if (n > 300) begin
        err_total++;
        results();
      end
      @(posedge clk_in);
    end
  endtask
  always @(posedge clk_in) begin
    if (rd_d) chk({1'b0, rdata}, {1'b0, exp_rd.pop_front()});
    rd_d = rd;
    if (ack && req) begin
      e_irq = exp_irq.pop_front();
      chk({high, vec}, e_irq);
      // index and vector must name the same source
      chk(9'(irq_sfr_pkg::VECTOR_TABLE[index]), 9'(e_irq[7:0]));
    end
  end
  initial begin
    v = 8'($urandom(32'ha4b1));
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    for (int j = 0; j < 7; j++) rd8(ad[j], on[j]);
    for (int j = 0; j < 21; j++) begin
      v = 8'($urandom);
      wr8(ad[j % 7], v);
      rd8(ad[j % 7], (v & wm[j % 7]) | on[j % 7]);
    end
    for (int j = 0; j < 7; j++) wr8(ad[j], 8'h00);
    for (int i = 0; i < 8; i++) begin
      k = (i < 4) ? i : 2 + i / 2;
      v = 8'($urandom);
      hold <= {3'b000, v[4:0]} + 8'd2;
      wr8(8'hb8, v);
      src[i] <= 1'b1;
      wr8(8'ha8, 8'h3f);
      repeat (3) @(posedge clk_in);
      chk(9'(req), 9'h0);
      wr8(8'ha8, 8'hbf ^ (8'h01 << k));
      repeat (3) @(posedge clk_in);
      chk(9'(req), 9'h0);
      exp_irq.push_back({v[k], irq_sfr_pkg::VECTOR_TABLE[k]});
      wr8(8'ha8, 8'h80 | (8'h01 << k));
      auto <= 1'b1;
      wait_on(1);
      auto <= 1'b0;
      src[i] <= 1'b0;
      wait_on(0);
    end
    wr8(8'ha8, 8'h80);
    for (int j = 0; j < 5; j++) begin
      fa = (j == 4) ? 8'hd8 : 8'h91;
      fb = (j == 4) ? 8'h08 : 8'h10 << j;
      fo = (j == 4) ? 8'h40 : 8'h08;
      v = 8'($urandom);
      hold <= {3'b000, v[4:0]} + 8'd2;
      wr8(8'hf8, v);
      wr8(8'he8, 8'h1f ^ (8'h01 << j));
      src[8 + j] <= 1'b1;
      @(posedge clk_in);
      if (j == 1 || j == 4) src[8 + j] <= 1'b0;
      rd8(fa, fo | fb);
      chk(9'(req), 9'h0);
      exp_irq.push_back({v[j], irq_sfr_pkg::VECTOR_TABLE[6 + j]});
      wr8(8'he8, 8'h01 << j);
      auto <= 1'b1;
      wait_on(1);
      auto <= 1'b0;
      wait_on(0);
      rd8(fa, fo | fb);
      chk(9'(req), 9'h1);
      wr8(fa, 8'h00);
      repeat (2) @(posedge clk_in);
      chk(9'(req), 9'h0);
      rd8(fa, fo);
      src[8 + j] <= 1'b0;
      exp_irq.push_back({v[j], irq_sfr_pkg::VECTOR_TABLE[6 + j]});
      wr8(fa, fb);
      auto <= 1'b1;
      wait_on(1);
      auto <= 1'b0;
      wait_on(0);
      wr8(fa, 8'h00);
    end
    hold <= 8'd20;
    wr8(8'hb8, 8'h08);
    wr8(8'hf8, 8'h01);
    wr8(8'ha8, 8'h89);
    wr8(8'he8, 8'h01);
    exp_irq.push_back({1'b0, irq_sfr_pkg::VECTOR_TABLE[0]});
    exp_irq.push_back({1'b1, irq_sfr_pkg::VECTOR_TABLE[6]});
    src[0] <= 1'b1;
    auto <= 1'b1;
    wait_on(1);
    src[8] <= 1'b1;
    wait_on(1);
    wr8(8'h91, 8'h00);
    src <= 13'h0000;
    wait_on(0);
    auto <= 1'b0;
    exp_irq.push_back({1'b1, irq_sfr_pkg::VECTOR_TABLE[3]});
    exp_irq.push_back({1'b1, irq_sfr_pkg::VECTOR_TABLE[6]});
    exp_irq.push_back({1'b0, irq_sfr_pkg::VECTOR_TABLE[0]});
    src <= 13'h0109;
    repeat (3) @(posedge clk_in);
    auto <= 1'b1;
    wait_on(1);
    src[3] <= 1'b0;
    wait_on(1);
    wr8(8'h91, 8'h00);
    wait_on(1);
    auto <= 1'b0;
    src <= 13'h0000;
    wait_on(0);
    results();
  end
endmodule
`default_nettype wire
